// ==== design/nvm_pkg.sv ====
package nvm_pkg;
    // ------------------------------------------------------------
    // peripheral register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRLA_OFS    = 8'h00;
    localparam logic [7:0]  CTRLB_OFS    = 8'h04;
    localparam logic [7:0]  ADDR_OFS     = 8'h08;
    localparam logic [7:0]  DATA_OFS     = 8'h0C;
    localparam logic [7:0]  REGION_OFS   = 8'h10;
    localparam logic [7:0]  FLAGS_OFS    = 8'h14;
    localparam logic [7:0]  STATUS_OFS   = 8'h18;
    localparam logic [7:0]  ATTRIB_OFS   = 8'h1C;

    localparam logic [7:0]  CMD_KEY      = 8'hA5;
    localparam int          KEY_LSB      = 8;
    localparam int          NREGIONS     = 6;
    localparam int          WS_W         = 4;
    localparam int          ATTRIB_NSWR  = 0;

    localparam logic [7:0]  FLAGS_RESET  = 8'h00;
    localparam int          FLAG_DONE    = 0;
    localparam int          FLAG_PROG    = 1;
    localparam int          FLAG_LOCK    = 2;
    localparam int          FLAG_ARRAY   = 3;
    localparam int          FLAG_KEY     = 4;
    localparam int          FLAG_SEC     = 5;
    localparam int          NFLAGS       = 6;

    // ------------------------------------------------------------
    // memory map and array geometry
    // ------------------------------------------------------------
    localparam int          AW           = 10;
    localparam logic [1:0]  SEC_MAIN     = 2'h0;
    localparam logic [1:0]  SEC_DATA     = 2'h1;
    localparam logic [1:0]  SEC_AUX      = 2'h2;
    localparam int          PROG_CYCLES  = 16;
    localparam logic [4:0]  PROG_CNT     = 5'(PROG_CYCLES);

    typedef enum logic [1:0] {
        CMD_NONE  = 2'h0,
        CMD_WRITE = 2'h1,
        CMD_ERASE = 2'h2
    } cmd_t;
endpackage

// ==== design/nvm_array.sv ====
`timescale 1ns/1ps
module nvm_array (
    // clock
    input  wire logic                     clk_i,
    // read port
    input  wire logic [nvm_pkg::AW-1:0]   rd_addr_i,
    output logic      [31:0]              rd_data_o,
    // write port
    input  wire logic                     wr_en_i,
    input  wire logic [nvm_pkg::AW-1:0]   wr_addr_i,
    input  wire logic [31:0]              wr_data_i
);
    import nvm_pkg::*;

    logic [31:0] mem [0:(1<<AW)-1];

    // separate read and write ports let one array program while another reads
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

// ==== design/nvm_wait.sv ====
`timescale 1ns/1ps
module nvm_wait (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     resetn_i,
    // control
    input  wire logic                     start_i,
    input  wire logic [nvm_pkg::WS_W-1:0] ws_i,
    output logic                          done_o
);
    import nvm_pkg::*;

    logic [WS_W:0] cnt_r;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r  <= '0;
            done_o <= 1'b0;
        end else if (start_i) begin
            cnt_r  <= {1'b0, ws_i} + (WS_W+1)'(1);
            done_o <= 1'b0;
        end else if (cnt_r == (WS_W+1)'(1)) begin
            cnt_r  <= '0;
            done_o <= 1'b1;
        end else begin
            if (cnt_r != '0) begin
                cnt_r <= cnt_r - (WS_W+1)'(1);
            end
            done_o <= 1'b0;
        end
    end
endmodule

// ==== design/nvm_ctrl.sv ====
`timescale 1ns/1ps
module nvm_ctrl (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     resetn_i,
    // memory-mapped port
    input  wire logic                     mem_sel_i,
    input  wire logic                     mem_write_i,
    input  wire logic [1:0]               mem_section_i,
    input  wire logic [nvm_pkg::AW-1:0]   mem_addr_i,
    input  wire logic [31:0]              mem_wdata_i,
    output logic      [31:0]              mem_rdata_o,
    output logic                          mem_ready_o,
    output logic                          mem_err_o,
    // peripheral port
    input  wire logic                     psel_i,
    input  wire logic                     penable_i,
    input  wire logic                     pwrite_i,
    input  wire logic [7:0]               paddr_i,
    input  wire logic [31:0]              pwdata_i,
    input  wire logic                     pnonsec_i,
    output logic      [31:0]              prdata_o,
    output logic                          pready_o,
    // power and error inputs, power status output
    input  wire logic                     sleep_i,
    input  wire logic                     array_fault_i,
    output logic                          powered_o
);
    import nvm_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_PROG} prog_state_t;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic [WS_W-1:0]     ws_r;
    logic                wake_first_r;
    logic [NREGIONS-1:0] lock_r;
    logic [AW+1:0]       cmd_addr_r;
    logic [31:0]         cmd_data_r;
    logic [7:0]          attrib_r;
    logic [7:0]          attrib_chk_r;
    logic [NFLAGS-1:0]   flags_r;
    logic [NFLAGS-1:0]   flag_set;
    logic [NFLAGS-1:0]   flag_clr;
    prog_state_t         pstate_r;
    logic [4:0]          pcnt_r;
    logic [AW-1:0]       prog_addr_r;
    logic [1:0]          prog_sec_r;
    logic [31:0]         prog_data_r;
    logic                sleep_q_r;

    logic p_wr;
    logic cmd_go;
    logic key_ok;
    logic cmd_bad;
    logic cmd_locked;
    logic flags_wr_ok;
    logic prog_end;
    logic [2:0] region;

    assign p_wr        = psel_i && penable_i && pwrite_i;
    assign key_ok      = pwdata_i[KEY_LSB +: 8] == CMD_KEY;
    assign region      = 3'(cmd_addr_r[AW-1 -: 3]);
    assign cmd_go      = p_wr && paddr_i == CTRLA_OFS && key_ok;
    // commands while busy or aimed at the aux array are rejected
    assign cmd_bad     = cmd_go && (pwdata_i[1:0] == 2'h3 || pstate_r != ST_IDLE
                         || cmd_addr_r[AW+1 -: 2] == SEC_AUX);
    assign cmd_locked  = cmd_go && !cmd_bad && region < 3'(NREGIONS) && lock_r[region];
    assign flags_wr_ok = !pnonsec_i || attrib_r[ATTRIB_NSWR];
    assign prog_end    = pstate_r == ST_PROG && pcnt_r == 5'h01;

    // ------------------------------------------------------------
    // peripheral register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ws_r         <= '0;
            wake_first_r <= 1'b0;
            lock_r       <= '0;
            cmd_addr_r   <= '0;
            cmd_data_r   <= '0;
            attrib_r     <= '0;
        end else if (p_wr) begin
            // region locks and commands need the key; attribution is secure-only
            if (paddr_i == CTRLB_OFS) begin
                ws_r         <= pwdata_i[WS_W-1:0];
                wake_first_r <= pwdata_i[WS_W];
            end else if (paddr_i == ADDR_OFS) begin
                cmd_addr_r <= pwdata_i[AW+1:0];
            end else if (paddr_i == DATA_OFS) begin
                cmd_data_r <= pwdata_i;
            end else if (paddr_i == REGION_OFS && key_ok) begin
                lock_r <= pwdata_i[NREGIONS-1:0];
            end else if (paddr_i == ATTRIB_OFS && !pnonsec_i) begin
                attrib_r <= pwdata_i[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // event flags
    // ------------------------------------------------------------
    always_comb begin
        flag_set             = '0;
        flag_set[FLAG_DONE]  = prog_end || (cmd_go && pwdata_i[1:0] == 2'h0);
        flag_set[FLAG_PROG]  = cmd_bad;
        flag_set[FLAG_LOCK]  = cmd_locked || (mem_sel_i && mem_write_i);
        flag_set[FLAG_ARRAY] = array_fault_i;
        flag_set[FLAG_KEY]   = p_wr && (paddr_i == CTRLA_OFS || paddr_i == REGION_OFS) && !key_ok;
        flag_set[FLAG_SEC]   = attrib_r != attrib_chk_r;
    end

    // an event in the cycle of its clear wins, so no event is lost
    assign flag_clr = (p_wr && paddr_i == FLAGS_OFS && flags_wr_ok) ? pwdata_i[NFLAGS-1:0] : '0;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flags_r      <= FLAGS_RESET[NFLAGS-1:0];
            attrib_chk_r <= '0;
        end else begin
            flags_r      <= (flags_r & ~flag_clr) | flag_set;
            attrib_chk_r <= attrib_r;
        end
    end

    // ------------------------------------------------------------
    // programming engine
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pstate_r    <= ST_IDLE;
            pcnt_r      <= '0;
            prog_addr_r <= '0;
            prog_sec_r  <= '0;
            prog_data_r <= '0;
        end else begin
            case (pstate_r)
                ST_IDLE: begin
                    if (cmd_go && !cmd_bad && !cmd_locked && pwdata_i[1:0] != 2'h0) begin
                        pstate_r    <= ST_PROG;
                        pcnt_r      <= PROG_CNT;
                        prog_addr_r <= cmd_addr_r[AW-1:0];
                        prog_sec_r  <= cmd_addr_r[AW+1 -: 2];
                        // erase is a program of all ones into the addressed word
                        prog_data_r <= pwdata_i[1:0] == CMD_ERASE ? 32'hFFFFFFFF : cmd_data_r;
                    end
                end
                default: begin
                    pcnt_r <= pcnt_r - 5'h01;
                    if (prog_end) begin
                        pstate_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // arrays: main, data, aux; data programs while main reads
    // ------------------------------------------------------------
    logic [31:0] rd_main, rd_data, rd_aux;
    logic        wr_main, wr_data;

    assign wr_main = prog_end && prog_sec_r == SEC_MAIN;
    assign wr_data = prog_end && prog_sec_r == SEC_DATA;

    nvm_array u_main (
        .clk_i     (clk_i),
        .rd_addr_i (mem_addr_i),
        .rd_data_o (rd_main),
        .wr_en_i   (wr_main),
        .wr_addr_i (prog_addr_r),
        .wr_data_i (prog_data_r)
    );

    nvm_array u_data (
        .clk_i     (clk_i),
        .rd_addr_i (mem_addr_i),
        .rd_data_o (rd_data),
        .wr_en_i   (wr_data),
        .wr_addr_i (prog_addr_r),
        .wr_data_i (prog_data_r)
    );

    // aux has no write path here; it is read-only on the memory port
    nvm_array u_aux (
        .clk_i     (clk_i),
        .rd_addr_i (mem_addr_i),
        .rd_data_o (rd_aux),
        .wr_en_i   (1'b0),
        .wr_addr_i (prog_addr_r),
        .wr_data_i (prog_data_r)
    );

    // ------------------------------------------------------------
    // memory-mapped read path with wait states and power gating
    // ------------------------------------------------------------
    logic       rd_busy_r;
    logic [1:0] rd_sec_r;
    logic       ws_done;
    logic       rd_start;
    logic       main_busy;

    // reads of the section being programmed stall; the other array keeps going
    assign main_busy = pstate_r == ST_PROG && prog_sec_r == mem_section_i;
    // the edge that completes a read still sees the request; it must not start another
    assign rd_start  = mem_sel_i && !mem_write_i && !rd_busy_r && !mem_ready_o
                       && powered_o && !main_busy;

    nvm_wait u_wait (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .start_i  (rd_start),
        .ws_i     (ws_r),
        .done_o   (ws_done)
    );

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            powered_o <= 1'b1;
            sleep_q_r <= 1'b0;
        end else begin
            sleep_q_r <= sleep_i;
            if (sleep_i) begin
                powered_o <= 1'b0;
            end else if (!wake_first_r && sleep_q_r) begin
                powered_o <= 1'b1;
            // wake on access trades a longer first read for lower sleep current
            end else if (wake_first_r && mem_sel_i) begin
                powered_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_busy_r   <= 1'b0;
            rd_sec_r    <= '0;
            mem_rdata_o <= '0;
            mem_ready_o <= 1'b0;
            mem_err_o   <= 1'b0;
        end else begin
            mem_ready_o <= 1'b0;
            mem_err_o   <= 1'b0;
            if (mem_sel_i && mem_write_i && !rd_busy_r && !mem_ready_o) begin
                // direct writes are refused; programming goes through commands
                mem_ready_o <= 1'b1;
                mem_err_o   <= 1'b1;
            end else if (rd_start) begin
                rd_busy_r <= 1'b1;
                rd_sec_r  <= mem_section_i;
            end else if (ws_done) begin
                rd_busy_r   <= 1'b0;
                mem_ready_o <= 1'b1;
                if (rd_sec_r == SEC_MAIN) begin
                    mem_rdata_o <= rd_main;
                end else if (rd_sec_r == SEC_DATA) begin
                    mem_rdata_o <= rd_data;
                end else if (rd_sec_r == SEC_AUX) begin
                    mem_rdata_o <= rd_aux;
                end else begin
                    mem_rdata_o <= '0;
                    mem_err_o   <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // peripheral read data
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_o <= '0;
            pready_o <= 1'b0;
        end else begin
            // data latched in setup stands through the access phase
            pready_o <= psel_i && !penable_i;
            if (psel_i && !penable_i && !pwrite_i) begin
                if (paddr_i == CTRLB_OFS) begin
                    prdata_o <= {27'h0, wake_first_r, ws_r};
                end else if (paddr_i == ADDR_OFS) begin
                    prdata_o <= {20'h0, cmd_addr_r};
                end else if (paddr_i == DATA_OFS) begin
                    prdata_o <= cmd_data_r;
                end else if (paddr_i == REGION_OFS) begin
                    prdata_o <= {26'h0, lock_r};
                end else if (paddr_i == FLAGS_OFS) begin
                    prdata_o <= {26'h0, flags_r};
                end else if (paddr_i == STATUS_OFS) begin
                    prdata_o <= {30'h0, powered_o, pstate_r != ST_IDLE};
                end else if (paddr_i == ATTRIB_OFS) begin
                    prdata_o <= {24'h0, attrib_r};
                end else begin
                    prdata_o <= '0;
                end
            end
        end
    end
endmodule

// ==== verification/nvm_ctrl_properties.sv ====
`timescale 1ns/1ps
module nvm_ctrl_checker (
    // clock and reset
    input  wire logic  clk_i,
    input  wire logic  resetn_i,
    // memory port
    input  wire logic  mem_sel_i,
    input  wire logic  mem_write_i,
    input  wire logic [1:0] mem_section_i,
    input  wire logic  mem_ready_o,
    input  wire logic  mem_err_o,
    // peripheral port and power
    input  wire logic  psel_i,
    input  wire logic  penable_i,
    input  wire logic  pready_o,
    input  wire logic  powered_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    AST_PREADY_AFTER_SETUP: assert property (psel_i && !penable_i |=> pready_o)
        else $error("setup phase not answered in the next cycle");
    AST_PREADY_IN_ACCESS: assert property (pready_o |-> psel_i && penable_i && $past(psel_i && !penable_i))
        else $error("peripheral ready outside an access phase");
    AST_PREADY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("peripheral ready held too long");
    AST_MEM_ERR_ON_WRITE: assert property (mem_err_o |-> mem_ready_o && mem_sel_i
        && (mem_write_i || mem_section_i == 2'h3))
        else $error("memory error without a refused request");
    AST_MEM_WRITE_REFUSED: assert property (mem_sel_i && mem_write_i && powered_o && !mem_ready_o |=> mem_ready_o && mem_err_o)
        else $error("memory write not refused in the next cycle");
    AST_READ_ANSWER: assert property ($rose(mem_sel_i) && !mem_write_i |=> !mem_ready_o ##[1:40]
        (mem_ready_o && mem_err_o == (mem_section_i == 2'h3)))
        else $error("memory read answered too early or too late");
    AST_READY_HELD_SEL: assert property (mem_ready_o |-> mem_sel_i)
        else $error("memory ready without a request");
    AST_READ_POWERED: assert property (mem_ready_o && !mem_err_o |-> powered_o)
        else $error("memory read answered while powered down");
endmodule

bind nvm_ctrl nvm_ctrl_checker nvm_ctrl_checker_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .mem_sel_i(mem_sel_i), .mem_write_i(mem_write_i),
    .mem_ready_o(mem_ready_o), .mem_err_o(mem_err_o), .psel_i(psel_i), .penable_i(penable_i),
    .pready_o(pready_o), .powered_o(powered_o), .mem_section_i(mem_section_i)
);

// ==== verification/nvm_bus_master.sv ====
`timescale 1ns/1ps
module nvm_bus_master (
    // clock
    input  wire logic                    clk_i,
    // peripheral port
    output logic                         psel_o,
    output logic                         penable_o,
    output logic                         pwrite_o,
    output logic                         pnonsec_o,
    output logic      [7:0]              paddr_o,
    output logic      [31:0]             pwdata_o,
    input  wire logic [31:0]             prdata_i,
    input  wire logic                    pready_i,
    // memory port
    output logic                         mem_sel_o,
    output logic                         mem_write_o,
    output logic      [1:0]              mem_section_o,
    output logic      [nvm_pkg::AW-1:0]  mem_addr_o,
    output logic      [31:0]             mem_wdata_o,
    input  wire logic [31:0]             mem_rdata_i,
    input  wire logic                    mem_ready_i,
    input  wire logic                    mem_err_i
);
    import nvm_pkg::*;
    initial begin
        {psel_o, penable_o, pwrite_o, pnonsec_o, mem_sel_o, mem_write_o} = '0;
        {paddr_o, pwdata_o, mem_section_o, mem_addr_o, mem_wdata_o} = '0;
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic ns,
                       output logic [31:0] q);
        @(negedge clk_i);
        psel_o = 1'b1;
        penable_o = 1'b0;
        pwrite_o = wr;
        pnonsec_o = ns;
        paddr_o = a;
        pwdata_o = d;
        @(negedge clk_i);
        penable_o = 1'b1;
        // a missing answer hangs here and is caught by the bench watchdog
        do begin
            @(posedge clk_i);
        end while (pready_i !== 1'b1);
        q = prdata_i;
        @(negedge clk_i);
        psel_o = 1'b0;
        penable_o = 1'b0;
        // idle bus must not keep showing the last transfer
        paddr_o = ~a;
        pwdata_o = ~d;
    endtask

    task automatic mem(input logic wr, input logic [1:0] s, input logic [AW-1:0] a,
                       input logic [31:0] d, output logic [31:0] q, output logic e, output int lat);
        @(negedge clk_i);
        mem_sel_o = 1'b1;
        mem_write_o = wr;
        mem_section_o = s;
        mem_addr_o = a;
        mem_wdata_o = d;
        lat = 0;
        do begin
            @(posedge clk_i);
            lat++;
        end while (mem_ready_i !== 1'b1);
        q = mem_rdata_i;
        e = mem_err_i;
        @(negedge clk_i);
        mem_sel_o = 1'b0;
        mem_write_o = 1'b0;
        mem_section_o = ~s;
        mem_addr_o = ~a;
        mem_wdata_o = ~d;
    endtask
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin fails++; $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
    import nvm_pkg::*;
    localparam logic [31:0] KEY = 32'(CMD_KEY) << KEY_LSB;
    logic clk = 1'b0, resetn = 1'b0, sleep = 1'b0, fault = 1'b0;
    logic psel, penable, pwrite, pnonsec, pready, mem_sel, mem_write, mem_ready, mem_err, powered, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, mem_wdata, mem_rdata, q;
    logic [1:0] mem_section;
    logic [AW-1:0] mem_addr;
    int fails = 0, checks = 0, lat, lat0;

    always #5 clk = ~clk;

    nvm_ctrl nvm_ctrl_inst (.clk_i(clk), .resetn_i(resetn), .mem_sel_i(mem_sel), .mem_write_i(mem_write),
        .mem_section_i(mem_section), .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata),
        .mem_ready_o(mem_ready), .mem_err_o(mem_err), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pnonsec_i(pnonsec), .prdata_o(prdata), .pready_o(pready),
        .sleep_i(sleep), .array_fault_i(fault), .powered_o(powered));
    nvm_bus_master nvm_bus_master_inst (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .pnonsec_o(pnonsec), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .mem_sel_o(mem_sel), .mem_write_o(mem_write), .mem_section_o(mem_section), .mem_addr_o(mem_addr),
        .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata), .mem_ready_i(mem_ready), .mem_err_i(mem_err));

    // --------------------------------
    // bus helpers
    // --------------------------------
    function automatic logic [7:0] fb(input int b);
        return 8'h01 << b;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ns = 1'b0);
        logic [31:0] dummy;
        nvm_bus_master_inst.apb(1'b1, a, d, ns, dummy);
    endtask
    task automatic flags(input logic [7:0] exp);
        nvm_bus_master_inst.apb(1'b0, FLAGS_OFS, 32'h0, 1'b0, q);
        `CHECK(q[7:0], exp)
    endtask
    task automatic mrd(input logic [1:0] s, input logic [AW-1:0] a);
        nvm_bus_master_inst.mem(1'b0, s, a, 32'h0, q, e, lat);
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // --------------------------------
    // tests
    // --------------------------------
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        stop_test();
    end

    initial begin
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        flags(FLAGS_RESET);
        `CHECK(powered, 1'b1)
        wr(CTRLA_OFS, 32'h1);
        flags(fb(FLAG_KEY));
        wr(FLAGS_OFS, 32'h0);
        flags(fb(FLAG_KEY));
        wr(FLAGS_OFS, 32'(fb(FLAG_KEY)));
        flags(8'h00);
        // lock write without the key is dropped and only raises the key flag; region 0 is reopened before the array test
        wr(REGION_OFS, 32'h3F);
        flags(fb(FLAG_KEY));
        wr(FLAGS_OFS, 32'hFF);
        wr(CTRLA_OFS, KEY | 32'(CMD_NONE));
        flags(fb(FLAG_DONE));
        wr(FLAGS_OFS, 32'hFF);
        wr(CTRLA_OFS, KEY | 32'h3);
        flags(fb(FLAG_PROG));
        wr(FLAGS_OFS, 32'hFF);
        wr(REGION_OFS, KEY | 32'h01);
        wr(ADDR_OFS, 32'h405);
        wr(DATA_OFS, 32'h1234_5678);
        wr(CTRLA_OFS, KEY | 32'(CMD_WRITE));
        flags(fb(FLAG_LOCK));
        wr(FLAGS_OFS, 32'hFF);
        $display("test key and commands done");
        wr(REGION_OFS, KEY | 32'h3E);
        wr(CTRLA_OFS, KEY | 32'(CMD_WRITE));
        mrd(SEC_MAIN, 10'h3);
        `CHECK(e, 1'b0)
        `CHECK(lat < 8, 1'b1)
        repeat (PROG_CYCLES) @(negedge clk);
        flags(fb(FLAG_DONE));
        mrd(SEC_DATA, 10'h5);
        `CHECK(q, 32'h1234_5678)
        mrd(SEC_AUX, 10'h0);
        `CHECK(e, 1'b0)
        mrd(2'h3, 10'h0);
        `CHECK(e, 1'b1)
        wr(FLAGS_OFS, 32'hFF);
        wr(CTRLA_OFS, KEY | 32'(CMD_ERASE));
        wr(CTRLA_OFS, KEY | 32'(CMD_WRITE));
        flags(fb(FLAG_PROG));
        repeat (PROG_CYCLES) @(negedge clk);
        mrd(SEC_DATA, 10'h5);
        `CHECK(q, 32'hFFFF_FFFF)
        wr(FLAGS_OFS, 32'hFF);
        wr(ADDR_OFS, 32'h800);
        wr(CTRLA_OFS, KEY | 32'(CMD_WRITE));
        flags(fb(FLAG_PROG));
        wr(FLAGS_OFS, 32'hFF);
        nvm_bus_master_inst.mem(1'b1, SEC_DATA, 10'h5, 32'hFFFF_FFFF, q, e, lat);
        `CHECK(e, 1'b1)
        flags(fb(FLAG_LOCK));
        wr(FLAGS_OFS, 32'hFF);
        @(negedge clk);
        fault = 1'b1;
        @(negedge clk);
        fault = 1'b0;
        flags(fb(FLAG_ARRAY));
        wr(FLAGS_OFS, 32'hFF);
        $display("test array done");
        wr(ATTRIB_OFS, 32'h1);
        flags(fb(FLAG_SEC));
        wr(FLAGS_OFS, 32'hFF, 1'b1);
        flags(8'h00);
        wr(ATTRIB_OFS, 32'h0);
        wr(FLAGS_OFS, 32'hFF, 1'b1);
        flags(fb(FLAG_SEC));
        wr(FLAGS_OFS, 32'hFF);
        wr(ATTRIB_OFS, 32'h0);
        wr(ATTRIB_OFS, 32'h1, 1'b1);
        flags(8'h00);
        $display("test security done");
        wr(CTRLB_OFS, 32'h0);
        mrd(SEC_MAIN, 10'h1);
        lat0 = lat;
        wr(CTRLB_OFS, 32'h5);
        mrd(SEC_MAIN, 10'h1);
        `CHECK((lat - lat0) inside {[4:6]}, 1'b1)
        wr(CTRLB_OFS, 32'h0);
        @(negedge clk);
        sleep = 1'b1;
        repeat (4) @(negedge clk);
        `CHECK(powered, 1'b0)
        sleep = 1'b0;
        repeat (2) @(negedge clk);
        `CHECK(powered, 1'b1)
        wr(CTRLB_OFS, 32'h10);
        @(negedge clk);
        sleep = 1'b1;
        repeat (4) @(negedge clk);
        sleep = 1'b0;
        repeat (4) @(negedge clk);
        `CHECK(powered, 1'b0)
        mrd(SEC_MAIN, 10'h2);
        `CHECK(e, 1'b0)
        `CHECK(powered, 1'b1)
        $display("test timing and power done");
        stop_test();
    end
endmodule
